/* File: src/ucs_uart.sv */
// UART control, status, transmitter and receiver with Wishbone registers
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module ucs_uart (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_i,
  input wire logic clock_off_i,
  output logic tx_o,
  output logic tx_oe_n_o,
  output logic rx_own_o,
  output logic irq_o,
  output logic wake_o
);
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic [7:0] divisor;
  logic tx_data_empty, tx_idle, rx_idle, rx_avail, overrun, frame_err, par_err, noise;
  logic [8:0] tx_hold, rx_hold;
  logic status_seen;
  logic tick;
  logic run, tx_run, rx_run;
  logic req, wr, rd, bus_lo;
  logic [8:0] tx_shift;
  logic [3:0] tx_bit, tx_sub, rx_bit, rx_sub;
  logic [3:0] brk_bits;
  logic tx_par, rx_par;
  ucs_pkg::ucs_state_t tx_state, rx_state;
  logic [8:0] rx_shift;
  logic rx_prev, rx_prev2;
  logic load_shift, rx_done, rx_keep;
  logic [3:0] nbits;

  assign run = ctrl_one[ucs_pkg::C1_GEN];
  assign tx_run = run && ctrl_two[ucs_pkg::C2_TX_EN];
  assign rx_run = run && ctrl_two[ucs_pkg::C2_RX_EN];
  assign req = cyc_i && stb_i && !ack_o;
  assign bus_lo = sel_i[0];
  assign wr = req && we_i && bus_lo;
  assign rd = req && !we_i;
  assign nbits = ctrl_one[ucs_pkg::C1_LEN9] ? 4'h9 : 4'h8;

  function automatic logic parity_of(input logic [8:0] d, input logic len9, input logic odd);
    parity_of = ^(len9 ? d : {1'b0, d[7:0]}) ^ odd;
  endfunction

  ucs_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Counter held in reset while disabled
    .run_i(run),
    .high_speed_i(ctrl_two[ucs_pkg::C2_HIGH_SPEED]),
    .divisor_i(divisor),
    .tick_o(tick)
  );

  // Bus slave: one wait state, unmapped reads zero, unmapped writes ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (rd) begin
        case (adr_i)
          {1'b0, ucs_pkg::ADDR_STATUS}: dat_o[7:0] <= {par_err, noise, frame_err, overrun,
                                               rx_idle, rx_avail, tx_idle, tx_data_empty};
          // Transmit ninth bit reads as zero
          {1'b0, ucs_pkg::ADDR_CTRL_ONE}: dat_o[7:0] <= {ctrl_one[7:2], rx_hold[8], 1'b0};
          {1'b0, ucs_pkg::ADDR_CTRL_TWO}: dat_o[7:0] <= ctrl_two;
          {1'b0, ucs_pkg::ADDR_DATA}: dat_o[7:0] <= rx_hold[7:0];
          ucs_pkg::ADDR_DIVISOR: dat_o[7:0] <= divisor;
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one <= ucs_pkg::CTRL_ONE_RESET;
      ctrl_two <= ucs_pkg::CTRL_TWO_RESET;
      divisor <= ucs_pkg::DIVISOR_RESET;
    end else begin
      if (wr && adr_i == {1'b0, ucs_pkg::ADDR_CTRL_ONE}) begin
        ctrl_one <= {dat_i[7:2], 1'b0, dat_i[0]};
      end
      if (wr && adr_i == {1'b0, ucs_pkg::ADDR_CTRL_TWO}) begin
        ctrl_two <= dat_i[7:0];
      end
      if (wr && adr_i == ucs_pkg::ADDR_DIVISOR) begin
        divisor <= dat_i[7:0];
      end
      // Disable clears enables and break; other bits kept
      if (!run) begin
        ctrl_two[ucs_pkg::C2_TX_EN] <= 1'b0;
        ctrl_two[ucs_pkg::C2_RX_EN] <= 1'b0;
        ctrl_one[ucs_pkg::C1_BREAK] <= 1'b0;
      end
      ctrl_one[ucs_pkg::C1_RX9] <= 1'b0;
    end
  end

  // Status read arms the clearing sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_seen <= 1'b0;
    end else if (rd && adr_i == {1'b0, ucs_pkg::ADDR_STATUS}) begin
      status_seen <= 1'b1;
    end else if (req && adr_i == {1'b0, ucs_pkg::ADDR_DATA}) begin
      status_seen <= 1'b0;
    end
  end

  // Transmit holding register and empty flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_empty <= 1'b1;
      tx_hold <= 9'h000;
    end else if (!tx_run) begin
      // Buffer empty whenever transmitter is off or being enabled
      tx_data_empty <= 1'b1;
    end else if (load_shift) begin
      // Shift register takes character; set wins over clear
      tx_data_empty <= 1'b1;
    end else if (wr && adr_i == {1'b0, ucs_pkg::ADDR_DATA}) begin
      // Write after status read clears flag
      tx_hold <= {ctrl_one[ucs_pkg::C1_TX9], dat_i[7:0]};
      if (status_seen) begin
        tx_data_empty <= 1'b0;
      end
    end
  end

  assign load_shift = tx_run && tx_state == ucs_pkg::UCS_IDLE && !tx_data_empty;

  // Transmitter
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_run) begin
      tx_state <= ucs_pkg::UCS_IDLE;
      tx_o <= 1'b1;
      tx_oe_n_o <= 1'b1;
      tx_idle <= 1'b1;
      tx_shift <= 9'h000;
      tx_bit <= 4'h0;
      tx_sub <= 4'h0;
      tx_par <= 1'b0;
      brk_bits <= 4'h0;
    end else begin
      // Pin driven while both enables set
      tx_oe_n_o <= 1'b0;
      case (tx_state)
        ucs_pkg::UCS_IDLE: begin
          tx_o <= 1'b1;
          tx_sub <= 4'h0;
          if (!tx_data_empty) begin
            tx_shift <= tx_hold;
            tx_par <= parity_of(tx_hold, ctrl_one[ucs_pkg::C1_LEN9],
                                ctrl_one[ucs_pkg::C1_PAR_ODD]);
            tx_idle <= 1'b0;
            tx_state <= ucs_pkg::UCS_START;
          end else if (ctrl_one[ucs_pkg::C1_BREAK]) begin
            tx_idle <= 1'b0;
            brk_bits <= 4'h0;
            tx_state <= ucs_pkg::UCS_BREAK;
          end else if (wr && adr_i == {1'b0, ucs_pkg::ADDR_DATA} && status_seen) begin
            tx_idle <= 1'b0;
          end else begin
            tx_idle <= 1'b1;
          end
        end
        ucs_pkg::UCS_START: begin
          tx_o <= 1'b0;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_bit <= 4'h0;
              tx_state <= ucs_pkg::UCS_DATA;
            end
          end
        end
        ucs_pkg::UCS_DATA: begin
          tx_o <= tx_shift[0];
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_shift <= {1'b0, tx_shift[8:1]};
              tx_bit <= tx_bit + 4'h1;
              if (tx_bit == nbits - 4'h1) begin
                tx_bit <= 4'h0;
                tx_state <= ctrl_one[ucs_pkg::C1_PAR_EN] ? ucs_pkg::UCS_PARITY
                                                         : ucs_pkg::UCS_STOP;
              end
            end
          end
        end
        ucs_pkg::UCS_PARITY: begin
          tx_o <= tx_par;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_state <= ucs_pkg::UCS_STOP;
            end
          end
        end
        ucs_pkg::UCS_STOP: begin
          tx_o <= 1'b1;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_bit <= tx_bit + 4'h1;
              if (tx_bit != 4'h0 || !ctrl_one[ucs_pkg::C1_STOP2]) begin
                tx_state <= ucs_pkg::UCS_IDLE;
              end
            end
          end
        end
        ucs_pkg::UCS_BREAK: begin
          // Low for at least 13 bits and until break cleared
          tx_o <= 1'b0;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF && brk_bits != ucs_pkg::BREAK_BITS) begin
              brk_bits <= brk_bits + 4'h1;
            end
          end
          if (brk_bits == ucs_pkg::BREAK_BITS && !ctrl_one[ucs_pkg::C1_BREAK]) begin
            tx_state <= ucs_pkg::UCS_IDLE;
          end
        end
        default: tx_state <= ucs_pkg::UCS_IDLE;
      endcase
    end
  end

  // Receiver
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_run) begin
      rx_state <= ucs_pkg::UCS_IDLE;
      rx_idle <= 1'b1;
      rx_shift <= 9'h000;
      rx_bit <= 4'h0;
      rx_sub <= 4'h0;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        ucs_pkg::UCS_IDLE: begin
          rx_idle <= 1'b1;
          rx_sub <= 4'h0;
          if (!rx_i) begin
            rx_idle <= 1'b0;
            rx_state <= ucs_pkg::UCS_START;
          end
        end
        ucs_pkg::UCS_START: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == ucs_pkg::HALF_TICKS) begin
              rx_sub <= 4'h0;
              rx_bit <= 4'h0;
              rx_state <= rx_i ? ucs_pkg::UCS_IDLE : ucs_pkg::UCS_DATA;
            end
          end
        end
        ucs_pkg::UCS_DATA: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'hF) begin
              rx_shift <= ctrl_one[ucs_pkg::C1_LEN9] ? {rx_i, rx_shift[8:1]}
                                                     : {1'b0, rx_i, rx_shift[7:1]};
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == nbits - 4'h1) begin
                rx_state <= ctrl_one[ucs_pkg::C1_PAR_EN] ? ucs_pkg::UCS_PARITY
                                                         : ucs_pkg::UCS_STOP;
              end
            end
          end
        end
        ucs_pkg::UCS_PARITY: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'hF) begin
              rx_par <= rx_i;
              rx_state <= ucs_pkg::UCS_STOP;
            end
          end
        end
        ucs_pkg::UCS_STOP: begin
          // Receiver always checks a single stop bit
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'hF) begin
              rx_done <= 1'b1;
              rx_state <= ucs_pkg::UCS_IDLE;
            end
          end
        end
        default: rx_state <= ucs_pkg::UCS_IDLE;
      endcase
    end
  end

  // Address bit is the top data bit
  assign rx_keep = !ctrl_two[ucs_pkg::C2_ADDR_DET] ||
                   (ctrl_one[ucs_pkg::C1_LEN9] ? rx_shift[8] : rx_shift[7]);

  // Receive flags
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_run) begin
      // Receive and error flags cleared on disable
      rx_avail <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      noise <= 1'b0;
      rx_hold <= 9'h000;
    end else if (rx_done && rx_keep) begin
      if (rx_avail) begin
        overrun <= 1'b1;
      end else begin
        rx_avail <= 1'b1;
        rx_hold <= rx_shift;
        frame_err <= !rx_i;
        par_err <= ctrl_one[ucs_pkg::C1_PAR_EN] && (rx_par != parity_of(rx_shift,
                   ctrl_one[ucs_pkg::C1_LEN9], ctrl_one[ucs_pkg::C1_PAR_ODD]));
      end
    end else if (status_seen && req && adr_i == {1'b0, ucs_pkg::ADDR_DATA}) begin
      // Status read then data access clears
      rx_avail <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      noise <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_own_o <= 1'b0;
      rx_prev <= 1'b1;
      rx_prev2 <= 1'b1;
    end else begin
      rx_own_o <= rx_run;
      rx_prev <= rx_i;
      rx_prev2 <= rx_prev;
    end
  end

  // Wake and interrupt request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Falling edge on RX while clock gated off
      wake_o <= ctrl_two[ucs_pkg::C2_WAKE] && clock_off_i && rx_prev2 && !rx_prev;
      irq_o <= (ctrl_two[ucs_pkg::C2_RX_IE] && (rx_avail || overrun)) ||
               (ctrl_two[ucs_pkg::C2_IDLE_IE] && tx_idle) ||
               (ctrl_two[ucs_pkg::C2_EMPTY_IE] && tx_data_empty) ||
               (ctrl_two[ucs_pkg::C2_WAKE] && clock_off_i && rx_prev2 && !rx_prev);
    end
  end
endmodule

/* File: src/ucs_pkg.sv */
// Constants, register map and field positions for the UART control block
// Notes on behaviour
// - Empty flag sets on shift-register load; clears on status read then data write.
// - Setting transmitter enable also sets the transmit-buffer-empty flag.
// - Global enable low releases TX/RX pins; high lets enables decide pin use.
// - Disable empties buffer, drops residual character, resets baud counter.
// - Disable clears enables, break, receive and error flags; sets idle and empty flags.
// - Disable aborts activity at once; other control and divisor bits keep values.
// - Length select picks 8 or 9 data bits; ninth bits held in register bits.
// - Parity generated and checked only while parity enable is set.
// - Parity type: zero even, one odd.
// - Stop select: zero one stop bit, one two stop bits.
// - Break waits for buffered data, drives TX low 13 bit times until cleared.
// - Received ninth bit read-only, transmitted ninth bit write-only.
// - Transmitter enable low aborts and resets transmitter; TX driven only with both enables.
// - Receiver enable low aborts and resets receiver; RX used only with both enables.
// - Baud speed select picks high or low speed generator mode.
// - Bit rate is fH/(64*(N+1)) low speed, fH/(16*(N+1)) high speed.
// - Address detect: address bit one keeps word, zero discards without interrupt.
// - Wake bit with fH off: RX falling edge raises wake request.
// - Receive interrupt enable lets overrun or receive-available set the request.
// - Idle interrupt enable lets transmitter-idle set the request.
// - Empty interrupt enable lets transmit-buffer-empty set the request.
// - Error flags clear by status read followed by data register access.
package ucs_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h4;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h8;
  localparam logic [3:0] ADDR_DATA = 4'hC;
  localparam logic [4:0] ADDR_DIVISOR = 5'h10;
  localparam logic [7:0] STATUS_RESET = 8'h0B;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  // Control one bit positions
  localparam int C1_GEN = 7;
  localparam int C1_LEN9 = 6;
  localparam int C1_PAR_EN = 5;
  localparam int C1_PAR_ODD = 4;
  localparam int C1_STOP2 = 3;
  localparam int C1_BREAK = 2;
  localparam int C1_RX9 = 1;
  localparam int C1_TX9 = 0;
  // Control two bit positions
  localparam int C2_TX_EN = 7;
  localparam int C2_RX_EN = 6;
  localparam int C2_HIGH_SPEED = 5;
  localparam int C2_ADDR_DET = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RX_IE = 2;
  localparam int C2_IDLE_IE = 1;
  localparam int C2_EMPTY_IE = 0;
  // Oversampling per bit
  localparam logic [5:0] LOW_SPEED_DIV = 6'h3F;
  localparam logic [5:0] HIGH_SPEED_DIV = 6'h0F;
  localparam logic [3:0] BREAK_BITS = 4'hD;
  localparam logic [3:0] HALF_TICKS = 4'h7;
  typedef enum logic [2:0] {
    UCS_IDLE = 3'b000,
    UCS_START = 3'b001,
    UCS_DATA = 3'b010,
    UCS_PARITY = 3'b011,
    UCS_STOP = 3'b100,
    UCS_BREAK = 3'b101
  } ucs_state_t;
endpackage

/* File: src/ucs_baud.sv */
// Baud tick generator: 16 ticks per bit
`timescale 1ns/10ps
module ucs_baud (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic high_speed_i,
  input wire logic [7:0] divisor_i,
  output logic tick_o
);
  logic [7:0] count;
  logic [1:0] pre;
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count <= 8'h00;
      pre <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      // At or above, so a smaller divisor never waits for a full counter wrap
      if (count >= divisor_i) begin
        count <= 8'h00;
        // Low speed needs four times the prescale of high speed
        if (high_speed_i || pre == 2'h3) begin
          pre <= 2'h0;
          tick_o <= 1'b1;
        end else begin
          pre <= pre + 2'h1;
        end
      end else begin
        count <= count + 8'h01;
      end
    end
  end
endmodule

/* File: verif/ucs_uart_checker.sv */
// Port-level assertions for the UART control block
`timescale 1ns/10ps
module ucs_uart_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic clock_off_i,
  input wire logic tx_oe_n_o,
  input wire logic rx_own_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  logic gen, txe, rxe, wk, wr;
  logic [2:0] ie;
  logic [1:0] quiet;
  assign wr = ack_o && we_i && sel_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow enables; a disable also drops both direction enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen <= 1'h0;
      txe <= 1'h0;
      rxe <= 1'h0;
      wk <= 1'h0;
      ie <= 3'h0;
    end else if (wr && adr_i == 5'h08) begin
      // Direction enables cannot be set while the block is off
      txe <= dat_i[7] && gen;
      rxe <= dat_i[6] && gen;
      wk <= dat_i[3];
      ie <= dat_i[2:0];
    end else if (wr && adr_i == 5'h04) begin
      gen <= dat_i[7];
      txe <= txe && dat_i[7];
      rxe <= rxe && dat_i[7];
    end
  end
  // Settling time after a register access before pin checks apply
  always_ff @(posedge clk_i) begin
    if (rst_i || ack_o) begin
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  property p_tx_pin; quiet == 2'h3 |-> tx_oe_n_o == !(gen && txe); endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx ownership wrong");
  property p_rx_pin; quiet == 2'h3 |-> rx_own_o == (gen && rxe); endproperty
  a_rx_pin: assert property (p_rx_pin) else $error("rx ownership wrong");
  property p_off_status; ack_o && !we_i && adr_i == 5'h00 && !gen |-> dat_o[7:0] == 8'h0B;
  endproperty
  a_off_status: assert property (p_off_status) else $error("disabled status");
  property p_irq_mask; quiet == 2'h3 && ie == 3'h0 && !wk |-> !irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
  property p_irq_off; quiet == 2'h3 && !gen && ie[1:0] != 2'h0 |-> irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("idle irq missing");
  property p_wake; wake_o |-> wk && $past(clock_off_i); endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_wake_pulse; wake_o |=> !wake_o; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
endmodule
bind ucs_uart ucs_uart_checker i_ucs_uart_checker (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clock_off_i(clock_off_i),
  .tx_oe_n_o(tx_oe_n_o), .rx_own_o(rx_own_o), .irq_o(irq_o), .wake_o(wake_o));

/* File: verif/ucs_peer.sv */
// Remote serial peer: decodes TX frames, sends RX frames
`timescale 1ns/10ps
module ucs_peer (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic [3:0] nbits_i,
  input wire logic [31:0] bit_i,
  output logic rx_o,
  output logic [11:0] word_o,
  output int gap_o
);
  int cyc = 0;
  int t0 = 0;
  initial rx_o = 1'h1;
  always @(posedge clk_i) cyc <= cyc + 1;
  // Sample mid-bit; gap is start-to-start of the last two frames
  initial begin
    forever begin
      @(negedge tx_i);
      gap_o = cyc - t0;
      t0 = cyc;
      word_o = 12'hFFF;
      repeat (bit_i / 2) @(posedge clk_i);
      for (int k = 0; k < 12; k++) begin
        if (k < nbits_i) begin
          repeat (bit_i) @(posedge clk_i);
          word_o[k] = tx_i;
        end
      end
    end
  end
  task automatic send(input logic [8:0] w, input int n);
    logic [11:0] f;
    f = {2'h3, w, 1'h0};
    // An 8-bit frame has its stop bit where the ninth data bit would sit
    if (n == 8) f[9] = 1'h1;
    for (int k = 0; k <= n + 1; k++) begin
      @(posedge clk_i);
      rx_o <= f[k];
      repeat (bit_i - 1) @(posedge clk_i);
    end
    repeat (bit_i * 2) @(posedge clk_i);
  endtask
endmodule

/* File: verif/ucs_uart_bench.sv */
// Self-checking bench for the UART control block
`timescale 1ns/10ps
module ucs_uart_bench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rx_i, clock_off_i;
  logic tx_o, tx_oe_n_o, rx_own_o, irq_o, wake_o, hs;
  logic [4:0] adr_i;
  logic [3:0] sel_i, f, nb;
  logic [31:0] dat_i, dat_o;
  logic [7:0] rd, b, dv;
  logic [8:0] d;
  logic [11:0] pw;
  int pg, n, lo, seed, bitlen;
  int err_total = 0;
  int checks_done = 0;
  int wakes = 0;
  ucs_uart i_ucs_uart (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_i(rx_i), .clock_off_i(clock_off_i), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o),
    .rx_own_o(rx_own_o), .irq_o(irq_o), .wake_o(wake_o));
  ucs_peer i_ucs_peer (.clk_i(clk_i), .tx_i(tx_o), .nbits_i(nb), .bit_i(bitlen),
    .rx_o(rx_i), .word_o(pw), .gap_o(pg));
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (wake_o === 1'h1) wakes <= wakes + 1;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    int k;
    k = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, v};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'h1 && k < 50);
    if (k >= 50) begin
      chk("ack", 1'h1, 1'h0);
      summarize();
    end
    rd = dat_o[7:0];
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // Read status until a flag reaches the wanted level
  task automatic poll(input int k, input logic v);
    int t;
    t = 0;
    rd[k] = ~v;
    while (rd[k] !== v && t < 3000) begin
      bus(1'h0, 5'h00, 8'h00);
      t++;
    end
    if (t >= 3000) begin
      chk("poll", 1'h1, 1'h0);
      summarize();
    end
  endtask
  // Bits after start: data, optional parity, stop bits padded with idle ones
  function automatic logic [11:0] frame(input logic [8:0] v, input logic [3:0] m);
    logic [11:0] w;
    w = m[3] ? {3'h7, v} : {4'hF, v[7:0]};
    if (m[2]) w[m[3] ? 9 : 8] = (m[3] ? ^v : ^v[7:0]) ^ m[1];
    return w;
  endfunction
  initial begin
    seed = 32'h3BA28339;
    {cyc_i, stb_i, we_i, clock_off_i} = 4'h0;
    adr_i = 5'h00;
    sel_i = 4'h1;
    dat_i = 32'h0;
    bitlen = 16;
    nb = 4'h9;
    rst_i = 1'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    bus(1'h1, 5'h14, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      bus(1'h0, 5'(k * 4), 8'h00);
      if (k != 3) chk("reg reset", (k == 0) ? 8'h0B : 8'h00, rd);
    end
    bus(1'h1, 5'h04, 8'h03);
    bus(1'h0, 5'h04, 8'h00);
    chk("ninth bits", 8'h00, rd & 8'hFD);
    $display("test registers finished");
    for (int i = 0; i < 5; i++) begin
      f = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($random(seed));
      hs = (i != 2);
      dv = 8'(i % 3);
      bitlen = (hs ? 16 : 64) * (dv + 1);
      nb = 4'(9 + f[3] + f[2] + f[0]);
      bus(1'h1, 5'h10, dv);
      bus(1'h1, 5'h04, {1'h1, f, 3'h0});
      bus(1'h1, 5'h08, {2'h3, hs, 5'h00});
      poll(0, 1'h1);
      d = 9'($random(seed));
      bus(1'h1, 5'h04, {1'h1, f, 2'h0, d[8]});
      bus(1'h1, 5'h0C, d[7:0]);
      poll(0, 1'h1);
      bus(1'h1, 5'h0C, d[7:0]);
      bus(1'h0, 5'h00, 8'h00);
      chk("tx empty clear", 1'h0, rd[0]);
      poll(1, 1'h1);
      chk("frame", frame(d, f), pw);
      // Free-running divider: the first start bit may lose up to one tick period
      n = (1 + nb) * bitlen;
      chk("frame length", 1'h1, pg - n >= 2 - bitlen / 16 && pg - n <= 1);
    end
    $display("test transmit finished");
    bitlen = 16;
    bus(1'h1, 5'h10, 8'h00);
    bus(1'h1, 5'h04, 8'h80);
    bus(1'h1, 5'h08, 8'hE4);
    chk("irq quiet", 1'h0, irq_o);
    b = 8'($random(seed));
    i_ucs_peer.send({1'h0, b}, 8);
    poll(2, 1'h1);
    chk("irq rx", 1'h1, irq_o);
    bus(1'h0, 5'h0C, 8'h00);
    chk("rx data", b, rd);
    bus(1'h0, 5'h00, 8'h00);
    chk("rx clear", 1'h0, rd[2]);
    chk("irq clear", 1'h0, irq_o);
    bus(1'h1, 5'h08, 8'hF4);
    i_ucs_peer.send({1'h0, b & 8'h7F}, 8);
    bus(1'h0, 5'h00, 8'h00);
    chk("addr drop", 1'h0, rd[2]);
    i_ucs_peer.send({1'h0, b | 8'h80}, 8);
    poll(2, 1'h1);
    bus(1'h0, 5'h0C, 8'h00);
    chk("addr keep", b | 8'h80, rd);
    $display("test receive finished");
    bus(1'h1, 5'h04, 8'h84);
    n = 0;
    while (tx_o !== 1'h0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) begin
      chk("break start", 1'h1, 1'h0);
      summarize();
    end
    // Clear at once: the low time must still reach the minimum
    bus(1'h1, 5'h04, 8'h80);
    lo = 0;
    repeat (20 * bitlen) begin
      @(posedge clk_i);
      if (tx_o === 1'h0) lo++;
    end
    chk("break length", 1'h1, lo >= 13 * bitlen - 4 && lo <= 15 * bitlen);
    $display("test break finished");
    bus(1'h1, 5'h08, 8'hE3);
    bus(1'h1, 5'h10, 8'h01);
    bitlen = 32;
    // Status read arms the data write, so a frame is really under way
    bus(1'h0, 5'h00, 8'h00);
    bus(1'h1, 5'h0C, 8'h55);
    repeat (40) @(posedge clk_i);
    bus(1'h1, 5'h04, 8'h30);
    chk("tx released", 1'h1, tx_oe_n_o);
    chk("tx idle level", 1'h1, tx_o);
    chk("rx released", 1'h0, rx_own_o);
    chk("irq idle", 1'h1, irq_o);
    // Quiet spell so the port checker sees the disabled state settle
    repeat (8) @(posedge clk_i);
    bus(1'h0, 5'h00, 8'h00);
    chk("off status", 8'h0B, rd);
    bus(1'h0, 5'h04, 8'h00);
    chk("off ctrl one", 8'h30, rd & 8'hFD);
    bus(1'h0, 5'h08, 8'h00);
    chk("off ctrl two", 8'h23, rd);
    bus(1'h0, 5'h10, 8'h00);
    chk("off divisor", 8'h01, rd);
    $display("test disable finished");
    bus(1'h1, 5'h08, 8'h08);
    clock_off_i <= 1'h1;
    i_ucs_peer.send(9'h0FF, 8);
    chk("wake", 1, wakes);
    clock_off_i <= 1'h0;
    i_ucs_peer.send(9'h0FF, 8);
    chk("no wake", 1, wakes);
    $display("test wake finished");
    summarize();
  end
endmodule
